// ---- tsq_pkg.sv ----
// Package for the arm/trigger sequencer block.
// Assumes one system clock and an APB register port.
package tsq_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_TIMER = 8'h08;
    localparam logic [3:0] SEQ0_PAGE = 4'h1;
    localparam logic [3:0] SEQ1_PAGE = 4'h2;
    localparam logic [3:0] OFS_CFG = 4'h0;
    localparam logic [3:0] OFS_DLY = 4'h4;
    localparam logic [3:0] OFS_ACT = 4'h8;
    localparam logic [3:0] OFS_OUT = 4'hC;
    // Control bit positions
    localparam int CTRL_INIT0 = 0;
    localparam int CTRL_INIT1 = 1;
    localparam int CTRL_ABORT = 2;
    localparam int CTRL_AUTO = 3;
    localparam int CTRL_BUSTRG = 4;
    // Event sources, also index into the event vector
    localparam logic [3:0] SRC_SELF = 4'h0;
    localparam logic [3:0] SRC_BUS = 4'h1;
    localparam logic [3:0] SRC_TIMER = 4'h2;
    localparam int NUM_SRC = 16;
    localparam int NUM_PIN = 11;
    // Routes 0..10: lines a/b, pins one..seven, network, jack
    localparam int NUM_DEST = 11;
    localparam logic [7:0] ONE_COUNT = 8'h01;
    typedef struct packed {
        logic [7:0] trigCount;
        logic [7:0] armCount;
        logic [3:0] trigSrc;
        logic [3:0] armSrc;
    } tsq_cfg_t;
    typedef struct packed {
        logic [15:0] trigDelay;
        logic [15:0] armDelay;
    } tsq_dly_t;
    typedef struct packed {
        logic [7:0] width;
        logic odType;
        logic polarity;
        logic [3:0] route;
        logic actAfter;
        logic actOutEn;
        logic trigAfter;
        logic trigOutEn;
        logic armAfter;
        logic armOutEn;
    } tsq_out_t;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ARMW = 8'h02,
        ST_ARMD = 8'h04,
        ST_TRGW = 8'h08,
        ST_TRGD = 8'h10,
        ST_ACTD = 8'h20,
        ST_ACT = 8'h40
    } tsq_state_t;
endpackage

// ---- tsq_top.sv ----
// Arm/trigger sequencer: two independent sequencers, APB slave,
// event source selection and trigger output routing.
// Assumes a single 50 MHz core_clk and APB master with 8-bit paddr.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////
// One sequencer instance
module tsq_seq
    import tsq_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic init,
    input wire logic abort,
    input wire logic fixedMode,
    input wire logic [NUM_SRC-1:0] evVec,
    input wire tsq_cfg_t cfg,
    input wire tsq_dly_t dly,
    input wire logic [15:0] actDly,
    input wire tsq_out_t outCfg,
    output logic actStrobe,
    output logic pulseOn,
    output logic [7:0] stateBits
);
    tsq_state_t state_reg, state_next; // Sequencer layer
    tsq_cfg_t cfgEff; // Config after auto override
    tsq_dly_t dlyEff;
    logic [15:0] actDlyEff;
    logic [15:0] dlyCnt_reg; // Shared delay counter
    logic [7:0] trigCnt_reg; // Actions done this arm cycle
    logic [7:0] armCnt_reg; // Arm cycles done
    logic [7:0] pulseCnt_reg; // Output pulse width counter
    logic pulseOn_reg;
    logic armEv, trigEv, lastTrig, lastArm, dlyDone, emit;

    // Fixed conditions in auto mode: self source, one pass, no delay
    always_comb
    begin
        cfgEff = cfg;
        dlyEff = dly;
        actDlyEff = actDly;
        if (fixedMode)
        begin
            cfgEff.armSrc = SRC_SELF;
            cfgEff.trigSrc = SRC_SELF;
            cfgEff.armCount = ONE_COUNT;
            cfgEff.trigCount = ONE_COUNT;
            dlyEff = '0;
            actDlyEff = '0;
        end
    end

    // Separate selections for arm and trigger events
    assign armEv = evVec[cfgEff.armSrc];
    assign trigEv = evVec[cfgEff.trigSrc];
    assign dlyDone = (dlyCnt_reg == '0);
    // Count of zero behaves as one
    assign lastTrig = ({1'b0, trigCnt_reg} + 9'h001) >= {1'b0, cfgEff.trigCount};
    assign lastArm = ({1'b0, armCnt_reg} + 9'h001) >= {1'b0, cfgEff.armCount};

    // Layer transitions and trigger output emission points
    always_comb
    begin
        state_next = state_reg;
        emit = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (init)
                begin
                    state_next = ST_ARMW;
                    emit = outCfg.armOutEn & ~outCfg.armAfter;
                end
            end
            ST_ARMW:
            begin
                if (armEv)
                    state_next = ST_ARMD;
            end
            ST_ARMD:
            begin
                if (dlyDone)
                begin
                    state_next = ST_TRGW;
                    emit = outCfg.trigOutEn & ~outCfg.trigAfter;
                end
            end
            ST_TRGW:
            begin
                if (trigEv)
                    state_next = ST_TRGD;
            end
            ST_TRGD:
            begin
                if (dlyDone)
                    state_next = ST_ACTD;
            end
            ST_ACTD:
            begin
                if (dlyDone)
                begin
                    state_next = ST_ACT;
                    emit = outCfg.actOutEn & ~outCfg.actAfter;
                end
            end
            ST_ACT:
            begin
                emit = outCfg.actOutEn & outCfg.actAfter;
                if (!lastTrig)
                    state_next = ST_TRGW;
                else
                begin
                    emit = emit | (outCfg.trigOutEn & outCfg.trigAfter);
                    if (lastArm)
                    begin
                        state_next = ST_IDLE;
                        emit = emit | (outCfg.armOutEn & outCfg.armAfter);
                    end
                    else
                        state_next = ST_ARMW;
                end
            end
        endcase
        if (abort)
        begin
            state_next = ST_IDLE;
            emit = 1'b0;
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Delay counter, loaded at the detected event or at the end of the trigger delay
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            dlyCnt_reg <= '0;
        else if (abort)
            dlyCnt_reg <= '0;
        else if (state_reg == ST_ARMW && armEv)
            dlyCnt_reg <= dlyEff.armDelay;
        else if (state_reg == ST_TRGW && trigEv)
            dlyCnt_reg <= dlyEff.trigDelay;
        else if (state_reg == ST_TRGD && dlyDone)
            dlyCnt_reg <= actDlyEff;
        else if (!dlyDone)
            dlyCnt_reg <= dlyCnt_reg - 16'h0001;
    end

    // Loop counters
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            trigCnt_reg <= '0;
            armCnt_reg <= '0;
        end
        else if (abort || state_reg == ST_IDLE)
        begin
            trigCnt_reg <= '0;
            armCnt_reg <= '0;
        end
        else if (state_reg == ST_ACT)
        begin
            trigCnt_reg <= lastTrig ? 8'h00 : trigCnt_reg + 8'h01;
            if (lastTrig)
                armCnt_reg <= lastArm ? 8'h00 : armCnt_reg + 8'h01;
        end
    end

    // Output pulse, width+1 cycles long
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pulseOn_reg <= 1'b0;
            pulseCnt_reg <= '0;
        end
        else if (abort)
        begin
            pulseOn_reg <= 1'b0;
            pulseCnt_reg <= '0;
        end
        else if (emit)
        begin
            pulseOn_reg <= 1'b1;
            pulseCnt_reg <= outCfg.width;
        end
        else if (pulseCnt_reg != '0)
            pulseCnt_reg <= pulseCnt_reg - 8'h01;
        else
            pulseOn_reg <= 1'b0;
    end

    assign actStrobe = (state_reg == ST_ACT);
    assign pulseOn = pulseOn_reg;
    assign stateBits = state_reg;

    // Checks
    sequence s_run;
        !abort;
    endsequence
    a_abort_idle: assert property (@(posedge core_clk) disable iff (reset)
        abort |=> state_reg == ST_IDLE && !pulseOn_reg) else $error("abort not honoured");
    a_init_arm: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == ST_IDLE && init) and s_run |=> state_reg == ST_ARMW) else $error("no arm");
    a_arm_hold: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == ST_ARMW && !armEv) and s_run |=> state_reg == ST_ARMW) else $error("arm left early");
    a_arm_delay: assert property (@(posedge core_clk) disable iff (reset)
        ((state_reg == ST_ARMW && armEv && dlyEff.armDelay == 16'h0000) and s_run) ##1 s_run
        |=> state_reg == ST_TRGW) else $error("zero arm delay");
    a_trig_hold: assert property (@(posedge core_clk) disable iff (reset)
        (state_reg == ST_TRGW && !trigEv) and s_run |=> state_reg == ST_TRGW) else $error("trig left early");
    a_act_once: assert property (@(posedge core_clk) disable iff (reset)
        actStrobe |=> !actStrobe) else $error("action repeated");
    a_trig_loop: assert property (@(posedge core_clk) disable iff (reset)
        (actStrobe && !lastTrig) and s_run |=> state_reg == ST_TRGW) else $error("no trig repeat");
    a_arm_end: assert property (@(posedge core_clk) disable iff (reset)
        (actStrobe && lastTrig && lastArm) and s_run |=> state_reg == ST_IDLE) else $error("no idle");
    // Any nonzero width keeps the pulse up for at least two cycles
    a_pulse_width: assert property (@(posedge core_clk) disable iff (reset)
        emit && outCfg.width != 8'h00 ##1 s_run [*2] |-> pulseOn_reg && $past(pulseOn_reg, 1))
        else $error("pulse width");
endmodule

////////////////////////////////////////////////////////////////
// Top: APB registers, sources, two sequencers, routing
module tsq_top
    import tsq_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] innerBusIn,
    input wire logic [6:0] rearIoIn,
    input wire logic netTrigIn,
    input wire logic trigJackIn,
    output logic [1:0] innerBusOut,
    output logic [1:0] innerBusOe,
    output logic [6:0] rearIoOut,
    output logic [6:0] rearIoOe,
    output logic netTrigOut,
    output logic netTrigOe,
    output logic trigJackOut,
    output logic trigJackOe,
    output logic srcActStrobe,
    output logic measActStrobe,
    output logic [1:0] seqBusy
);
    tsq_cfg_t cfg_reg [2]; // Per sequencer sources and counts
    tsq_dly_t dly_reg [2]; // Arm and trigger delays
    logic [15:0] actDly_reg [2]; // Source or measure delay
    tsq_out_t out_reg [2]; // Trigger output setup
    logic [15:0] period_reg; // Timer period minus one, in cycles
    logic [15:0] timerCnt_reg;
    logic autoRun_reg; // Continuous measurement mode
    logic [1:0] initPulse_reg; // Single-run initiate requests
    logic abortPulse_reg;
    logic busTrg_reg; // Bus trigger event
    logic [31:0] prdata_reg;
    logic [NUM_PIN-1:0] sync1_reg, sync2_reg, prev_reg; // Pin synchronisers
    logic [NUM_PIN-1:0] pinEdge;
    logic timerTick;
    logic [NUM_SRC-1:0] evVec;
    logic [1:0] initVec, abortVec, fixedVec, actVec, pulseVec;
    logic [7:0] stateBits [2];
    logic [NUM_DEST-1:0] destOut, destOe;
    logic wrEn, setup, isSeq, hit;
    logic seqIdx;

    ////////////////////////////////////////////////////////////
    // APB decode, zero wait states
    assign setup = psel & ~penable;
    assign wrEn = psel & penable & pwrite;
    assign isSeq = (paddr[7:4] == SEQ0_PAGE) || (paddr[7:4] == SEQ1_PAGE);
    assign seqIdx = (paddr[7:4] == SEQ1_PAGE);
    assign hit = isSeq || paddr == ADDR_CTRL || paddr == ADDR_STAT || paddr == ADDR_TIMER;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit; // Access outside the control, status, timer and both sequencer pages
    assign prdata = prdata_reg;

    // Register writes; command bits are one-cycle pulses
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cfg_reg <= '{default: '0};
            dly_reg <= '{default: '0};
            actDly_reg <= '{default: '0};
            out_reg <= '{default: '0};
            period_reg <= '0;
            autoRun_reg <= 1'b0;
            initPulse_reg <= '0;
            abortPulse_reg <= 1'b0;
            busTrg_reg <= 1'b0;
        end
        else
        begin
            initPulse_reg <= '0;
            abortPulse_reg <= 1'b0;
            busTrg_reg <= 1'b0;
            if (wrEn && paddr == ADDR_CTRL)
            begin
                initPulse_reg <= {pwdata[CTRL_INIT1], pwdata[CTRL_INIT0]};
                abortPulse_reg <= pwdata[CTRL_ABORT];
                autoRun_reg <= pwdata[CTRL_AUTO];
                busTrg_reg <= pwdata[CTRL_BUSTRG];
            end
            else if (wrEn && paddr == ADDR_TIMER)
                period_reg <= pwdata[15:0];
            else if (wrEn && isSeq)
            begin
                unique case (paddr[3:0])
                    OFS_CFG: cfg_reg[seqIdx] <= tsq_cfg_t'(pwdata[$bits(tsq_cfg_t)-1:0]);
                    OFS_DLY: dly_reg[seqIdx] <= pwdata;
                    OFS_ACT: actDly_reg[seqIdx] <= pwdata[15:0];
                    OFS_OUT: out_reg[seqIdx] <= tsq_out_t'(pwdata[$bits(tsq_out_t)-1:0]);
                    default: ;
                endcase
            end
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            prdata_reg <= '0;
        else if (setup)
        begin
            prdata_reg <= '0;
            if (paddr == ADDR_CTRL)
                prdata_reg[CTRL_AUTO] <= autoRun_reg;
            else if (paddr == ADDR_STAT)
                prdata_reg[15:0] <= {stateBits[1], stateBits[0]};
            else if (paddr == ADDR_TIMER)
                prdata_reg[15:0] <= period_reg;
            else if (isSeq)
            begin
                unique case (paddr[3:0])
                    OFS_CFG: prdata_reg[$bits(tsq_cfg_t)-1:0] <= cfg_reg[seqIdx];
                    OFS_DLY: prdata_reg <= dly_reg[seqIdx];
                    OFS_ACT: prdata_reg[15:0] <= actDly_reg[seqIdx];
                    OFS_OUT: prdata_reg[$bits(tsq_out_t)-1:0] <= out_reg[seqIdx];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Periodic timer source
    assign timerTick = (timerCnt_reg >= period_reg);
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            timerCnt_reg <= '0;
        else if (timerTick)
            timerCnt_reg <= '0;
        else
            timerCnt_reg <= timerCnt_reg + 16'h0001;
    end

    // Pin synchronisers and rising-edge detection
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            sync1_reg <= {trigJackIn, netTrigIn, rearIoIn, innerBusIn};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    assign pinEdge = sync2_reg & ~prev_reg;
    assign evVec = {2'b00, pinEdge, timerTick, busTrg_reg, 1'b1};

    ////////////////////////////////////////////////////////////
    // Auto mode: measurement restarts, source held idle
    assign initVec = {initPulse_reg[1] | autoRun_reg, initPulse_reg[0] & ~autoRun_reg};
    assign abortVec = {abortPulse_reg, abortPulse_reg | autoRun_reg};
    assign fixedVec = {autoRun_reg, 1'b0};

    // Two independent sequencers: 0 source, 1 measurement
    for (genvar g = 0; g < 2; g++)
    begin : gSeq
        tsq_seq uSeq (
            .core_clk(core_clk),
            .reset(reset),
            .init(initVec[g]),
            .abort(abortVec[g]),
            .fixedMode(fixedVec[g]),
            .evVec(evVec),
            .cfg(cfg_reg[g]),
            .dly(dly_reg[g]),
            .actDly(actDly_reg[g]),
            .outCfg(out_reg[g]),
            .actStrobe(actVec[g]),
            .pulseOn(pulseVec[g]),
            .stateBits(stateBits[g])
        );
        assign seqBusy[g] = ~stateBits[g][0];
    end
    assign srcActStrobe = actVec[0];
    assign measActStrobe = actVec[1];

    // Output routing; sequencer 0 wins a shared destination
    for (genvar d = 0; d < NUM_DEST; d++)
    begin : gDest
        logic sel0, sel1;
        assign sel0 = (out_reg[0].route == 4'(d));
        assign sel1 = (out_reg[1].route == 4'(d));
        assign destOut[d] = sel0 ? (pulseVec[0] ^ out_reg[0].polarity)
            : sel1 ? (pulseVec[1] ^ out_reg[1].polarity) : 1'b0;
        assign destOe[d] = (sel0 & (~out_reg[0].odType | pulseVec[0]))
            | (~sel0 & sel1 & (~out_reg[1].odType | pulseVec[1]));
    end
    assign innerBusOut = destOut[1:0];
    assign innerBusOe = destOe[1:0];
    assign rearIoOut = destOut[8:2];
    assign rearIoOe = destOe[8:2];
    assign netTrigOut = destOut[9];
    assign netTrigOe = destOe[9];
    assign trigJackOut = destOut[10];
    assign trigJackOe = destOe[10];

    a_auto_nosrc: assert property (@(posedge core_clk) disable iff (reset)
        autoRun_reg |=> !srcActStrobe) else $error("source ran in auto");
endmodule

`default_nettype wire

// ---- tsq_far_end.sv ----
// Far-side instrument model: pulses one rear I/O pin on request.
// Assumes core_clk from the bench; pins rest low between pulses.
`timescale 1ns/10ps
`default_nettype none
module tsq_far_end
    import tsq_pkg::*;
(
    input wire logic core_clk,
    input wire logic fire,
    input wire logic [2:0] pinSel,
    output logic [6:0] rearIoIn
);
    logic [2:0] holdCnt = 3'h0; // Pulse cycles left
    // One four-cycle pulse per request
    always @(posedge core_clk)
    begin
        if (fire === 1'b1)
            holdCnt <= 3'h4;
        else if (holdCnt != 3'h0)
            holdCnt <= holdCnt - 3'h1;
    end
    // Rising edge on the chosen pin is the event
    assign rearIoIn = (holdCnt != 3'h0) ? (7'h01 << pinSel) : 7'h00;
endmodule
`default_nettype wire

// ---- test_tsq_top.sv ----
// Self-checking bench: APB master, strobe monitors, count model.
// Assumes tsq_pkg, tsq_top and tsq_far_end are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_tsq_top
    import tsq_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rdv, rnd = 32'h0000_9121;
    logic pready, pslverr, errv, trigJackOut, trigJackOe, srcActStrobe, measActStrobe, netTrigOe;
    logic [1:0] seqBusy, innerBusOe;
    logic [6:0] rearIoIn, rearIoOe;
    logic [2:0] pinSel = 3'h0;
    int errors = 0, check_count = 0, srcN = 0, measN = 0, jackN = 0, lat, lat0, s0, m0, j0, k, w;
    tsq_top tsq_top_inst (.core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .innerBusIn(2'h0), .rearIoIn(rearIoIn), .netTrigIn(1'b0),
        .trigJackIn(1'b0), .innerBusOut(), .innerBusOe(innerBusOe), .rearIoOut(), .rearIoOe(rearIoOe),
        .netTrigOut(), .netTrigOe(netTrigOe), .trigJackOut(trigJackOut), .trigJackOe(trigJackOe),
        .srcActStrobe(srcActStrobe), .measActStrobe(measActStrobe), .seqBusy(seqBusy));
    tsq_far_end tsq_far_end_inst (.core_clk(core_clk), .fire(fire), .pinSel(pinSel),
        .rearIoIn(rearIoIn));
    ////////////////////////////////////////////////////////////////
    // Clock and monitors of actions and jack pulse cycles
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (srcActStrobe === 1'b1) srcN <= srcN + 1;
        if (measActStrobe === 1'b1) measN <= measN + 1;
        if (trigJackOut === 1'b1) jackN <= jackN + 1;
    end
    ////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Model of action count per run, count 0 runs once
    function automatic int ops(input int a, input int t);
        return (a == 0 ? 1 : a) * (t == 0 ? 1 : t);
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // One APB transfer, setup then access until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic snap();
        s0 = srcN;
        m0 = measN;
        j0 = jackN;
    endtask
    // Initiate sequencer s; ev 1 holds for a pin event, 2 for a bus event
    task automatic go(input int s, input int ev);
        int n;
        snap();
        apb(1'b1, ADDR_CTRL, 32'h1 << s);
        for (n = 0; n < 50 && seqBusy[s] !== 1'b1; n++) @(posedge core_clk);
        check("started", seqBusy[s], 1'b1);
        if (ev != 0)
        begin
            repeat (20) @(posedge core_clk);
            check("held", seqBusy[s], 1'b1);
            check("early act", srcN, s0);
            if (ev == 1)
                fire <= 1'b1;
            else
                apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_BUSTRG);
            @(posedge core_clk);
            fire <= 1'b0;
        end
        for (; n < 3000 && seqBusy[s] !== 1'b0; n++) @(posedge core_clk);
        check("run ends", seqBusy[s], 1'b0);
        lat = n;
        repeat (2) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        #200us;
        errors++;
        conclude();
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        apb(1'b0, ADDR_STAT, 32'h0);
        check("idle state", rdv, 32'h0000_0101);
        apb(1'b0, 8'h3C, 32'h0);
        check("unmapped err", errv, 1'b1);
        check("unmapped data", rdv, 32'h0);
        // Nested loops: trigger count 3, arm count 2
        apb(1'b1, 8'h10, 32'h0003_0200);
        go(0, 0);
        check("src actions", srcN - s0, ops(2, 3));
        check("meas idle", measN, m0);
        go(1, 0);
        check("meas once", measN - m0, ops(0, 0));
        lat0 = lat;
        // Random delays add exactly their cycle counts
        rnd = xs(rnd);
        apb(1'b1, 8'h24, {12'h0, rnd[7:4], 12'h0, rnd[3:0]});
        apb(1'b1, 8'h28, {28'h0, rnd[11:8]});
        go(1, 0);
        check("delays", lat - lat0, rnd[3:0] + rnd[7:4] + rnd[11:8]);
        // Arm from a random rear pin, action pulse routed to the jack
        rnd = xs(rnd);
        k = rnd % 7;
        w = rnd[15:12];
        pinSel <= 3'(k);
        apb(1'b1, 8'h10, {16'h0101, 4'h0, 4'(5 + k)});
        apb(1'b1, 8'h1C, {12'h0, 8'(w), 2'b00, 4'hA, 6'h10});
        go(0, 1);
        check("pin action", srcN - s0, 1);
        check("pulse width", jackN - j0, w + 1);
        check("jack drive", trigJackOe, 1'b1);
        // Only the jack and line a (sequencer 1, route 0) are driven
        check("pins idle", rearIoOe, 7'h00);
        check("net idle", netTrigOe, 1'h0);
        check("line a drive", innerBusOe, 2'h1);
        apb(1'b1, 8'h1C, {12'h0, 8'(w), 2'b01, 4'hA, 6'h10});
        check("polarity", trigJackOut, 1'b1);
        // Trigger from the host bus command
        apb(1'b1, 8'h10, 32'h0001_0110);
        go(0, 2);
        check("bus action", srcN - s0, 1);
        // Abort while waiting on a silent source, arm-after emit enabled
        apb(1'b1, 8'h10, 32'h0001_010F);
        apb(1'b1, 8'h1C, 32'h0000_0283);
        snap();
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_INIT0);
        repeat (10) @(posedge core_clk);
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_ABORT);
        repeat (3) @(posedge core_clk);
        check("abort idle", seqBusy, 2'b00);
        check("abort quiet", jackN, j0);
        // Auto run: measurement repeats, source action never
        snap();
        apb(1'b1, ADDR_CTRL, 32'h9);
        repeat (100) @(posedge core_clk);
        check("auto meas", measN - m0 > 2, 1'b1);
        check("auto src", srcN, s0);
        check("auto src idle", seqBusy[0], 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_ABORT);
        repeat (5) @(posedge core_clk);
        check("stopped", seqBusy, 2'b00);
        conclude();
    end
endmodule
`default_nettype wire
